// *** nvrom_map.vh ***
// Constants for the nonvolatile byte store reader
// Operation
// - 1 kbit storage as eight 128-bit banks
// - Each bank reads as 16 bytes
// - Only JTAG port may write contents
// - Program whole banks; others keep contents
// - Erase bank automatically before programming it
// - Synchronous byte-aligned reads on access clock
// - Address upper three bank, lower four byte
// - Address at rise, data valid next fall; this reader registers the data on the next rise instead
// - Unchanged address is re-read every cycle; this reader re-reads it every two enabled cycles
`ifndef NVROM_MAP_VH
`define NVROM_MAP_VH
`define NV_BANKS         8
`define NV_BANK_BITS     128
`define NV_BYTES_PER_BANK 16
`define NV_ADDR_W        7
`define NV_BANK_MSB      6
`define NV_BANK_LSB      4
`define NV_BYTE_MSB      3
`define NV_BYTE_LSB      0
`define NV_WORDS         128
`define NV_JTAG_BITS_W   7
`define NV_CLK_MHZ       125
`define NV_ACC_MAX_MHZ   20
`define NV_ACC_DIV       ((`NV_CLK_MHZ + `NV_ACC_MAX_MHZ - 1) / `NV_ACC_MAX_MHZ)
`define NV_ERASE_BYTE    8'h00
`endif

// *** nonvolatile_byte_rom_reader.v ***
// Byte-wide read port of an eight-bank nonvolatile store, written only by JTAG
`timescale 1ns/100ps
`include "nvrom_map.vh"
module nonvolatile_byte_rom_reader (
   input  wire       ref_clk,
   input  wire       rst_b,
   input  wire       clk_en,
   input  wire [6:0] rd_addr,
   output reg  [7:0] rd_data_r,
   output reg        rd_valid_r,
   input  wire       jtag_prog_req,
   input  wire [2:0] jtag_bank,
   input  wire [7:0] jtag_wr_byte,
   input  wire       jtag_wr_strobe,
   output reg        jtag_busy_r
);
   localparam ST_IDLE  = 3'b001;
   localparam ST_ERASE = 3'b010;
   localparam ST_LOAD  = 3'b100;

   // Store contents; the fabric has no write path here
   reg [7:0] mem [0:`NV_WORDS-1];
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [3:0] idx_r;
   reg [2:0] bank_r;
   reg [1:0] req_sync_r;
   reg [1:0] stb_sync_r;
   reg       stb_seen_r;
   reg       phase_r;
   reg [6:0] addr_r;
   reg [2:0] bank_sync1_r;
   reg [2:0] bank_sync2_r;
   reg [7:0] byte_sync1_r;
   reg [7:0] byte_sync2_r;

   wire       stb_rise = stb_sync_r[1] & ~stb_seen_r;
   wire [6:0] wr_ptr   = {bank_r, idx_r};

   // JTAG pins come from another domain, so they are synchronised
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         req_sync_r <= 2'b00;
         stb_sync_r <= 2'b00;
         stb_seen_r <= 1'b0;
      end else if (clk_en) begin
         req_sync_r <= {req_sync_r[0], jtag_prog_req};
         bank_sync1_r <= jtag_bank;
         bank_sync2_r <= bank_sync1_r;
         // Byte path has the strobe's latency, so it lines up with stb_rise
         byte_sync1_r <= jtag_wr_byte;
         byte_sync2_r <= byte_sync1_r;
         stb_sync_r <= {stb_sync_r[0], jtag_wr_strobe};
         stb_seen_r <= stb_sync_r[1];
      end
   end

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:  if (req_sync_r[1]) state_nxt = ST_ERASE;
         ST_ERASE: if (idx_r == 4'hF) state_nxt = ST_LOAD;
         ST_LOAD:  if (stb_rise && idx_r == 4'hF) state_nxt = ST_IDLE;
         default:  state_nxt = ST_IDLE;
      endcase
   end

   // Only the latched bank is touched; other banks keep contents
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         state_r     <= ST_IDLE;
         idx_r       <= 4'h0;
         bank_r      <= 3'h0;
         jtag_busy_r <= 1'b0;
      end else if (clk_en) begin
         state_r     <= state_nxt;
         jtag_busy_r <= (state_nxt != ST_IDLE);
         case (state_r)
            ST_IDLE: begin
               idx_r  <= 4'h0;
               bank_r <= bank_sync2_r;
            end
            ST_ERASE: begin
               mem[wr_ptr] <= `NV_ERASE_BYTE;
               idx_r <= idx_r + 4'h1;
            end
            ST_LOAD: begin
               if (stb_rise) begin
                  mem[wr_ptr] <= byte_sync2_r;
                  idx_r <= idx_r + 4'h1;
               end
            end
            default: idx_r <= 4'h0;
         endcase
      end
   end

   // Access phase: address taken on first half, byte presented on second.
   // Every two enabled cycles re-read even an unchanged address, and valid drops
   // at every new access, mirroring the per-cycle invalid window.
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         phase_r    <= 1'b0;
         addr_r     <= 7'h00;
         rd_data_r  <= 8'h00;
         rd_valid_r <= 1'b0;
      end else if (clk_en) begin
         phase_r <= ~phase_r;
         if (!phase_r) begin
            addr_r     <= rd_addr;
            rd_valid_r <= 1'b0;
         end else begin
            // Upper bits pick the bank, lower the byte
            rd_data_r  <= mem[{addr_r[`NV_BANK_MSB:`NV_BANK_LSB],
                               addr_r[`NV_BYTE_MSB:`NV_BYTE_LSB]}];
            rd_valid_r <= 1'b1;
         end
      end
   end
endmodule

// *** nv_chk_assertions.sv ***
// Read port and programming checks
`timescale 1ns/100ps
module nv_chk(input wire ref_clk, rst_b, clk_en, rd_valid_r, jtag_prog_req, jtag_busy_r,
   input wire [7:0] rd_data_r);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b || !clk_en);
   property p_tog; rd_valid_r |=> !rd_valid_r; endproperty
   a_tog: assert property (p_tog) else $error("valid stuck");
   property p_ans; !rd_valid_r && $past(rst_b) |=> rd_valid_r; endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_hold; rd_valid_r |=> $stable(rd_data_r); endproperty
   a_hold: assert property (p_hold) else $error("data moved");
   property p_ers; $rose(jtag_busy_r) |-> jtag_busy_r[*8]; endproperty
   a_ers: assert property (p_ers) else $error("busy short");
   property p_src; $rose(jtag_busy_r) |-> $past(jtag_prog_req); endproperty
   a_src: assert property (p_src) else $error("busy unasked");
   property p_frz; disable iff (!rst_b) !clk_en |=> $stable(rd_data_r) && $stable(rd_valid_r)
      && $stable(jtag_busy_r); endproperty
   a_frz: assert property (p_frz) else $error("state moved while frozen");
endmodule
bind nonvolatile_byte_rom_reader nv_chk u_chk(.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
   .rd_valid_r(rd_valid_r), .jtag_prog_req(jtag_prog_req), .jtag_busy_r(jtag_busy_r),
   .rd_data_r(rd_data_r));

// *** nv_reader.sv ***
// Fabric reader: moves its address only between rising edges
`timescale 1ns/100ps
module nv_reader(input wire ref_clk, input wire [6:0] want, output reg [6:0] rd_addr = 7'h00);
   // Caller holds each address for several cycles; the store still re-reads it every two enabled cycles
   always @(negedge ref_clk) rd_addr <= want;
endmodule

// *** nonvolatile_byte_rom_reader_tb.sv ***
// Programs banks, then reads every byte of banks 0 and 7 back against a model
`timescale 1ns/100ps
module nonvolatile_byte_rom_reader_tb;
   reg ref_clk = 0, rst_b = 0, rq = 0, st = 0, ce = 1;
   reg [2:0] bk = 0;
   reg [7:0] wb = 0;
   reg [6:0] w = 0;
   wire [6:0] a;
   wire [7:0] d;
   wire v, b;
   int m[128], mismatches = 0, checks = 0, i, n, t;
   nv_reader r(.ref_clk(ref_clk), .want(w), .rd_addr(a));
   nonvolatile_byte_rom_reader dut(.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(ce),
      .rd_addr(a), .rd_data_r(d), .rd_valid_r(v), .jtag_prog_req(rq), .jtag_bank(bk),
      .jtag_wr_byte(wb), .jtag_wr_strobe(st), .jtag_busy_r(b));
   initial forever #4 ref_clk = ~ref_clk;
   task end_of_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task cmp(input [7:0] s, input [7:0] e);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected %0t got %h want %h", $time, s, e);
      end
   endtask
   task wt(input x);
      for (t = 0; b !== x; t++) begin
         if (t > 200) begin
            mismatches++;
            end_of_test;
         end
         @(negedge ref_clk);
      end
   endtask
   // Strobe held 4 cycles each way so the synchroniser sees every edge
   task pg(input [2:0] k);
      bk = k;
      rq = 1;
      wt(1);
      rq = 0;
      // Strobes before the 16 erase cycles end would be ignored
      repeat (20) @(negedge ref_clk);
      for (n = 0; n < 16; n++) begin
         wb = $urandom;
         m[{k, n[3:0]}] = wb;
         repeat (4) @(negedge ref_clk);
         st = 1;
         repeat (4) @(negedge ref_clk);
         st = 0;
      end
      wt(0);
      $display("bank %0d programmed", k);
   endtask
   task rc(input [6:0] x);
      w = x;
      repeat (5) @(negedge ref_clk);
      if (v !== 1'b1) @(negedge ref_clk);
      cmp({7'h00, v}, 8'h01);
      cmp(d, 8'(m[x]));
   endtask
   initial begin
      void'($urandom(32'hB00F895C));
      repeat (4) @(negedge ref_clk);
      rst_b = 1;
      pg(0);
      pg(7);
      pg(0);
      for (i = 0; i < 32; i++) begin
         if (i == 16) begin
            ce = 0;
            repeat (3) @(negedge ref_clk);
            ce = 1;
         end
         rc({i[0] ? 3'h7 : 3'h0, i[4:1]});
      end
      $display("readback done");
      end_of_test;
   end
endmodule
